// file: logic/rpm_ctrl.sv
// reset combiner, reset sequencer, power control register and clock gates
`timescale 1ns/100ps
module rpm_ctrl
   import rpm_pkg::*;
(
   // clock and power-on reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // reset sources
   input  wire logic         ext_rst_in,
   input  wire logic         hw_wd_ovf_in,
   input  wire logic         ca_wd_match_in,
   // supply monitor: high when supply is above 3 V
   input  wire logic         vcc_ok_in,
   // cpu side
   input  wire rpm_wr_t      pwr_ctl_wr_in,
   input  wire logic         irq_in,
   input  wire logic         ext_irq_in,
   input  wire logic         code_external_in,
   input  wire logic         frame_err_in,
   input  wire logic         mode_bit_in,
   input  wire logic         ser_bit7_wr_in,
   input  wire logic         ser_bit7_data_in,
   // outputs
   output logic [7:0]        power_control_reg_out,
   output logic              power_loss_flag_out,
   output logic              baud_doubler_select_out,
   output logic              frame_error_view_select_out,
   output logic              ser_bit7_rd_out,
   output logic              framing_error_flag_wr_out,
   output logic              serial_mode_bit_zero_wr_out,
   output logic              ser_bit7_wdata_out,
   output logic              cpu_rst_out,
   output logic              sfr_load_out,
   output logic              cfg_fetch_out,
   output logic              vector_out,
   output logic [23:0]       vector_addr_out,
   output logic              cpu_halt_out,
   output logic              cpu_clk_out,
   output logic              periph_clk_out,
   output logic              osc_enable_out,
   output logic              first_ale_out,
   output rpm_mode_t         mode_out,
   output rpm_pin_ctl_t      pin_ctl_out
);
   // synchroniser for external reset
   logic ext_s1_r;
   logic ext_s2_r;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_rst_in;
         ext_s2_r <= ext_s1_r;
      end
   end

   logic wd_rst;
   rpm_wd_stretch u_wd (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .hw_wd_ovf_in   (hw_wd_ovf_in),
      .ca_wd_match_in (ca_wd_match_in),
      .wd_rst_out     (wd_rst)
   );

   wire comb_rst = ext_s2_r | wd_rst;

   // pins forced straight from the request, no clock needed
   wire async_req = ext_rst_in | hw_wd_ovf_in | ca_wd_match_in | wd_rst;

   // sample every 2 periods
   logic phase_r;
   logic seen_r;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_r <= 1'b0;
         seen_r  <= 1'b1;
      end else begin
         phase_r <= ~phase_r;
         if (phase_r)
            seen_r <= comb_rst;
      end
   end

   // reset sequencer
   rpm_seq_t   seq_r, seq_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   always_comb begin
      seq_nxt = seq_r;
      cnt_nxt = cnt_r;
      case (seq_r)
         RPM_S_HOLD: begin
            cnt_nxt = 6'h00;
            if (!seen_r)
               seq_nxt = RPM_S_SYNC;
         end
         RPM_S_SYNC: seq_nxt = RPM_S_CFG;
         RPM_S_CFG:  seq_nxt = RPM_S_WAIT;
         RPM_S_WAIT: begin
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == ALE_DELAY_CNT - 6'h03)
               seq_nxt = RPM_S_GO;
         end
         RPM_S_GO:   seq_nxt = RPM_S_GO;
         default:    seq_nxt = RPM_S_HOLD;
      endcase
      if (seen_r)
         seq_nxt = RPM_S_HOLD;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         seq_r <= RPM_S_HOLD;
         cnt_r <= 6'h00;
      end else begin
         seq_r <= seq_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   logic go_d_r;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         go_d_r <= 1'b0;
      else
         go_d_r <= (seq_r == RPM_S_GO);
   end

   assign cpu_rst_out     = (seq_r != RPM_S_GO);
   assign sfr_load_out    = (seq_r == RPM_S_HOLD);
   assign cfg_fetch_out   = (seq_r == RPM_S_CFG);
   assign first_ale_out   = (seq_r == RPM_S_GO) & ~go_d_r;
   assign vector_out      = first_ale_out;
   assign vector_addr_out = {VEC_PAGE, VEC_ADDR};

   // power control register, split so each half has one process
   logic [7:2] upper_r;
   logic [1:0] req_r;
   logic       vcc_d_r;
   wire pwr_rise   = vcc_ok_in & ~vcc_d_r;
   wire wake_idle  = irq_in;
   wire wake_pdown = ext_irq_in;

   // power-on reset only; other resets spare the loss flag
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         vcc_d_r <= 1'b0;
         upper_r <= PWR_CTL_RST[7:2];
      end else begin
         vcc_d_r <= vcc_ok_in;
         if (seen_r) begin
            upper_r[7:5] <= PWR_CTL_RST[7:5];
            upper_r[3:2] <= PWR_CTL_RST[3:2];
         end else if (pwr_ctl_wr_in.wr) begin
            upper_r[7:5] <= pwr_ctl_wr_in.data[7:5];
            upper_r[3:2] <= pwr_ctl_wr_in.data[3:2];
         end
         // hardware set wins over a write in the same cycle
         if (pwr_rise)
            upper_r[LOSS_FLAG_BIT] <= 1'b1;
         else if (pwr_ctl_wr_in.wr)
            upper_r[LOSS_FLAG_BIT] <= pwr_ctl_wr_in.data[LOSS_FLAG_BIT];
      end
   end

   // mode bits: pin high clears at once, before the sequencer
   wire mode_clr_n = rst_n_in & ~ext_rst_in;
   always_ff @(posedge clk_in or negedge mode_clr_n) begin
      if (!mode_clr_n) begin
         req_r <= 2'h0;
      end else if (seen_r) begin
         req_r <= 2'h0;
      end else if (req_r[PDOWN_REQ_BIT]) begin
         if (wake_pdown)
            req_r <= 2'h0;
      end else if (req_r[IDLE_REQ_BIT]) begin
         if (wake_idle)
            req_r[IDLE_REQ_BIT] <= 1'b0;
      end else if (pwr_ctl_wr_in.wr) begin
         req_r <= pwr_ctl_wr_in.data[1:0];
      end
   end

   wire pdown_on = req_r[PDOWN_REQ_BIT];
   wire idle_on  = req_r[IDLE_REQ_BIT] & ~pdown_on;

   assign mode_out = pdown_on ? RPM_PDOWN :
                     (idle_on ? RPM_IDLE : RPM_RUN);
   assign cpu_halt_out   = pdown_on | idle_on;
   assign osc_enable_out = ~pdown_on;

   // state is held simply by not clocking it
   rpm_clk_gate u_cpu_gate (
      .clk_in   (clk_in),
      .en_in    (~(pdown_on | idle_on)),
      .gclk_out (cpu_clk_out)
   );
   rpm_clk_gate u_per_gate (
      .clk_in   (clk_in),
      .en_in    (~pdown_on),
      .gclk_out (periph_clk_out)
   );

   assign power_control_reg_out       = {upper_r, req_r};
   assign power_loss_flag_out         = upper_r[LOSS_FLAG_BIT];
   assign baud_doubler_select_out     = upper_r[BAUD_DBL_BIT];
   assign frame_error_view_select_out = upper_r[VIEW_SEL_BIT];

   // serial control bit 7 view
   wire view_err = upper_r[VIEW_SEL_BIT];
   assign ser_bit7_rd_out = view_err ? frame_err_in : mode_bit_in;
   assign framing_error_flag_wr_out   = ser_bit7_wr_in & view_err;
   assign serial_mode_bit_zero_wr_out = ser_bit7_wr_in & ~view_err;
   assign ser_bit7_wdata_out = ser_bit7_data_in;

   // pin control: request forces reset state combinationally
   wire in_reset  = async_req | cpu_rst_out;
   wire strobe_hi = in_reset | idle_on;
   wire port0_flt = in_reset | (cpu_halt_out & code_external_in);
   assign pin_ctl_out = '{strobes_weak_high: strobe_hi,
                          port123_weak_high: in_reset,
                          port0_float:       port0_flt,
                          strobes_force_low: ~in_reset & pdown_on};
endmodule : rpm_ctrl

// file: common/rpm_pkg.sv
// constants, types and mode encodings for reset and power-mode control
// Summary of operation
// - after reset, sync, fetch config, vector FF:0000
// - external pin or either watchdog starts reset
// - 5-bit counter stretches watchdog reset to 64
// - combine requests; CPU samples every 2 periods
// - reset loads registers, RAM untouched
// - pins forced to reset state without clock
// - reset: strobes and ports 1-3 weak high
// - first address strobe 32 periods after release
// - power-loss flag set on rise, software, reset-proof
// - view select routes serial bit 7 to flag
// - baud doubler bit feeds serial port
// - idle or powerdown bit halts execution
// - idle stops CPU clock, peripherals keep running
// - idle keeps CPU state and memories
// - idle strobes high, port 0 floats if external
// - interrupt in idle clears bit, resumes CPU
// - idle with powerdown together enters powerdown
// - reset pin clears idle bit asynchronously
// - powerdown stops oscillator and all clocks
package rpm_pkg;
   localparam int          OSC_PERIOD_NS   = 4;
   localparam int          RST_HOLD_OSC    = 64;
   localparam int          ALE_DELAY_OSC   = 32;
   localparam int          SAMPLE_OSC      = 2;
   localparam logic [4:0]  WD_STRETCH_LAST = 5'h1F;
   localparam logic [5:0]  ALE_DELAY_CNT   = 6'(ALE_DELAY_OSC - 1);
   localparam logic [7:0]  VEC_PAGE        = 8'hFF;
   localparam logic [15:0] VEC_ADDR        = 16'h0000;
   localparam logic [7:0]  PWR_CTL_RST     = 8'h00;
   localparam int          IDLE_REQ_BIT    = 0;
   localparam int          PDOWN_REQ_BIT   = 1;
   localparam int          LOSS_FLAG_BIT   = 4;
   localparam int          VIEW_SEL_BIT    = 6;
   localparam int          BAUD_DBL_BIT    = 7;
   localparam int          SER_CTL_MSB     = 7;

   typedef enum logic [1:0] {RPM_RUN, RPM_IDLE, RPM_PDOWN} rpm_mode_t;
   typedef enum logic [2:0] {RPM_S_HOLD, RPM_S_SYNC, RPM_S_CFG,
                             RPM_S_WAIT, RPM_S_GO} rpm_seq_t;

   typedef struct packed {
      logic       strobes_weak_high;
      logic       port123_weak_high;
      logic       port0_float;
      logic       strobes_force_low;
   } rpm_pin_ctl_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } rpm_wr_t;
endpackage : rpm_pkg

// file: logic/rpm_wd_stretch.sv
// watchdog reset stretcher, 5-bit counter
`timescale 1ns/100ps
module rpm_wd_stretch
   import rpm_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // watchdog requests
   input  wire logic hw_wd_ovf_in,
   input  wire logic ca_wd_match_in,
   // stretched request
   output logic      wd_rst_out
);
   logic [4:0] cnt_r;
   logic       busy_r;
   wire        fire = hw_wd_ovf_in | ca_wd_match_in;

   // 32 counts of 2 oscillator periods each give 64 periods
   logic       half_r;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r  <= 5'h00;
         busy_r <= 1'b0;
         half_r <= 1'b0;
      end else if (fire) begin
         cnt_r  <= 5'h00;
         busy_r <= 1'b1;
         half_r <= 1'b0;
      end else if (busy_r) begin
         half_r <= ~half_r;
         if (half_r) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == WD_STRETCH_LAST)
               busy_r <= 1'b0;
         end
      end
   end

   assign wd_rst_out = busy_r | fire;
endmodule : rpm_wd_stretch

// file: logic/rpm_clk_gate.sv
// glitch-free clock gate for the cpu and peripheral clocks
`timescale 1ns/100ps
module rpm_clk_gate (
   // clock
   input  wire logic clk_in,
   // enable, passed while clock is low, held from the rising edge
   input  wire logic en_in,
   // gated clock
   output logic      gclk_out
);
   logic en_lat_r;
   // enable changes only while clk is low, so no runt pulse
   always_latch begin
      if (!clk_in)
         en_lat_r <= en_in;
   end
   assign gclk_out = clk_in & en_lat_r;
endmodule : rpm_clk_gate

// file: sim/rpm_ctrl_asserts.sv
// concurrent checks on the reset and power-mode controller ports
`timescale 1ns/100ps
module rpm_ctrl_asserts
   import rpm_pkg::*;
(
   input wire logic         clk_in,
   input wire logic         rst_n_in,
   input wire logic         ext_rst_in,
   input wire logic         vcc_ok_in,
   input wire rpm_wr_t      pwr_ctl_wr_in,
   input wire logic         irq_in,
   input wire logic         frame_err_in,
   input wire logic         mode_bit_in,
   input wire logic         frame_error_view_select_out,
   input wire logic         ser_bit7_rd_out,
   input wire logic         power_loss_flag_out,
   input wire logic         cpu_rst_out,
   input wire logic         cpu_halt_out,
   input wire logic         osc_enable_out,
   input wire logic [23:0]  vector_addr_out,
   input wire rpm_mode_t    mode_out,
   input wire rpm_pin_ctl_t pin_ctl_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // mode bits are only taken from a clean running state
   wire run_wr = pwr_ctl_wr_in.wr && mode_out == RPM_RUN
                 && !cpu_rst_out && !ext_rst_in;
   vec_addr_a: assert property (
      vector_addr_out == {VEC_PAGE, VEC_ADDR})
      else $error("reset vector address wrong");
   rst_seen_a: assert property (
      $rose(ext_rst_in) |-> ##[0:6] cpu_rst_out)
      else $error("external reset not passed on");
   pins_forced_a: assert property (
      ext_rst_in |-> pin_ctl_out.strobes_weak_high
         && pin_ctl_out.port123_weak_high && pin_ctl_out.port0_float)
      else $error("pins not forced during reset");
   loss_flag_a: assert property (
      $rose(vcc_ok_in) |-> ##[0:2] power_loss_flag_out)
      else $error("power loss flag not set on supply rise");
   view_mux_a: assert property (
      ser_bit7_rd_out ==
         (frame_error_view_select_out ? frame_err_in : mode_bit_in))
      else $error("serial bit 7 view wrong");
   idle_entry_a: assert property (
      run_wr && pwr_ctl_wr_in.data[1:0] == 2'h1
      |=> cpu_halt_out && mode_out == RPM_IDLE)
      else $error("idle write did not halt");
   idle_wake_a: assert property (
      mode_out == RPM_IDLE && irq_in |-> ##[1:2] !cpu_halt_out)
      else $error("interrupt did not end idle");
   pd_wins_a: assert property (
      run_wr && pwr_ctl_wr_in.data[1:0] == 2'h3 |=> mode_out == RPM_PDOWN)
      else $error("both bits did not give powerdown");
   osc_stop_a: assert property (
      mode_out == RPM_PDOWN |-> !osc_enable_out)
      else $error("oscillator runs in powerdown");
endmodule : rpm_ctrl_asserts

bind rpm_ctrl rpm_ctrl_asserts u_rpm_ctrl_asserts (.*);

// file: sim/rpm_board.sv
// board model: oscillator clock driver and external reset source
`timescale 1ns/100ps
module rpm_board
   import rpm_pkg::*;
(
   // board outputs
   output logic clk_out,
   output logic ext_rst_out
);
   initial clk_out = 1'b0;
   initial ext_rst_out = 1'b0;
   always #(OSC_PERIOD_NS / 2.0) clk_out = ~clk_out;
   // board only drives reset and clock, never the strobes
   task automatic hold_rst(input int n);
      @(negedge clk_out);
      ext_rst_out = 1'b1;
      repeat (n) @(negedge clk_out);
      ext_rst_out = 1'b0;
   endtask : hold_rst
endmodule : rpm_board

// file: sim/tb_top.sv
// self-checking bench for reset and power-mode control
`timescale 1ns/100ps
module tb_top
   import rpm_pkg::*;
;
   logic clk_in, rst_n_in, ext_rst_in, hw_wd_ovf_in, ca_wd_match_in;
   logic vcc_ok_in, irq_in, ext_irq_in, code_external_in;
   logic frame_err_in, mode_bit_in, ser_bit7_wr_in, ser_bit7_data_in;
   logic power_loss_flag_out, ser_bit7_rd_out;
   logic baud_doubler_select_out, frame_error_view_select_out;
   logic framing_error_flag_wr_out, serial_mode_bit_zero_wr_out;
   logic cpu_rst_out, sfr_load_out, cpu_halt_out, cpu_clk_out;
   logic periph_clk_out, osc_enable_out, first_ale_out;
   logic [7:0]   power_control_reg_out;
   logic [23:0]  vector_addr_out;
   rpm_wr_t      pwr_ctl_wr_in;
   rpm_mode_t    mode_out;
   rpm_pin_ctl_t pin_ctl_out;
   int           fail_count = 0;
   int           n_compared = 0;
   int           ncpu, nper;

   rpm_board u_rpm_board (.clk_out(clk_in), .ext_rst_out(ext_rst_in));
   rpm_ctrl u_rpm_ctrl (.*, .cfg_fetch_out(), .vector_out(),
                        .ser_bit7_wdata_out());

   always @(posedge cpu_clk_out) ncpu++;
   always @(posedge periph_clk_out) nper++;

   task automatic cmp_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bit
   task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask : tick
   // one-cycle write, taken at the single rising edge it spans
   task automatic wr_pwr_ctl(input logic [7:0] d);
      @(negedge clk_in);
      pwr_ctl_wr_in = '{1'b1, d};
      tick(1);
      pwr_ctl_wr_in.wr = 1'b0;
   endtask : wr_pwr_ctl
   // bounded wait, a missing strobe shows as a large count
   task automatic wait_ale(output int n);
      n = 0;
      while (first_ale_out !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
   endtask : wait_ale
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test

   initial begin
      #(OSC_PERIOD_NS * 5000);
      fail_count++;
      end_of_test();
   end

   initial begin
      int n;
      {hw_wd_ovf_in, ca_wd_match_in, vcc_ok_in, irq_in, ext_irq_in} = '0;
      {code_external_in, frame_err_in, mode_bit_in} = '0;
      {ser_bit7_wr_in, ser_bit7_data_in} = '0;
      pwr_ctl_wr_in = '0;
      rst_n_in = 1'b0;
      tick(3);
      rst_n_in = 1'b1;
      wait_ale(n);
      cmp_bit(n <= ALE_DELAY_OSC + 8, 1'b1);
      cmp_val(power_control_reg_out, PWR_CTL_RST);
      vcc_ok_in = 1'b1;
      tick(3);
      cmp_bit(power_loss_flag_out, 1'b1);
      wr_pwr_ctl(8'h80);
      cmp_bit(power_loss_flag_out, 1'b0);
      cmp_bit(baud_doubler_select_out, 1'b1);
      for (int v = 0; v < 2; v++) begin
         wr_pwr_ctl(v ? 8'h50 : 8'h10);
         frame_err_in = 1'b1;
         ser_bit7_wr_in = 1'b1;
         tick(1);
         cmp_bit(ser_bit7_rd_out, v[0]);
         cmp_bit(framing_error_flag_wr_out, v[0]);
         cmp_bit(serial_mode_bit_zero_wr_out, !v[0]);
         ser_bit7_wr_in = 1'b0;
      end
      wr_pwr_ctl(8'h11);
      cmp_bit(cpu_halt_out, 1'b1);
      cmp_val(mode_out, RPM_IDLE);
      tick(1);
      ncpu = 0;
      nper = 0;
      tick(8);
      cmp_bit(ncpu == 0 && nper >= 7, 1'b1);
      irq_in = 1'b1;
      tick(2);
      irq_in = 1'b0;
      cmp_bit(cpu_halt_out, 1'b0);
      cmp_bit(power_control_reg_out[0], 1'b0);
      wr_pwr_ctl(8'h13);
      cmp_val(mode_out, RPM_PDOWN);
      cmp_bit(osc_enable_out, 1'b0);
      ext_irq_in = 1'b1;
      tick(3);
      ext_irq_in = 1'b0;
      cmp_bit(cpu_halt_out, 1'b0);
      wr_pwr_ctl(8'h11);
      fork
         u_rpm_board.hold_rst(RST_HOLD_OSC);
      join_none
      // sync, sample phase and sequencer need up to five edges
      tick(8);
      cmp_val(pin_ctl_out, 24'h00000E);
      cmp_bit(power_control_reg_out[0], 1'b0);
      cmp_bit(cpu_rst_out && sfr_load_out, 1'b1);
      wait (ext_rst_in === 1'b0);
      wait_ale(n);
      cmp_bit(n >= ALE_DELAY_OSC && n <= ALE_DELAY_OSC + 8, 1'b1);
      cmp_val(power_control_reg_out, 24'h000010);
      cmp_val(vector_addr_out, 24'hFF0000);
      for (int s = 0; s < 2; s++) begin
         hw_wd_ovf_in = (s == 0);
         ca_wd_match_in = (s == 1);
         tick(1);
         {hw_wd_ovf_in, ca_wd_match_in} = '0;
         wait_ale(n);
         cmp_bit(n >= RST_HOLD_OSC + ALE_DELAY_OSC - 4, 1'b1);
         cmp_bit(n <= RST_HOLD_OSC + ALE_DELAY_OSC + 12, 1'b1);
      end
      end_of_test();
   end
endmodule : tb_top
